// File: design/dfcr_regs.sv
// I2C target register bank steering a digitally pulled oscillator.
`timescale 1ns/1ns
`default_nettype none

module dfcr_regs
  import dfcr_pkg::*;
#(
  parameter logic [6:0] TARGET_ADDR = 7'h2a,
  parameter logic [3:0] PR_RESET    = 4'h0
)(
  input  wire logic               clk,
  input  wire logic               nrst,
  input  wire logic               scl_i,
  input  wire logic               sda_i,
  output logic                    sda_o,
  output logic                    sda_oe,
  input  wire logic               oe_sw_mode,
  input  wire logic               oe_pin,
  output logic                    out_enable,
  output logic signed [25:0]      freq_offset_word,
  output logic                    freq_commit,
  output logic [3:0]              pull_range_sel
);

  // Pin synchronisers; the third stage serves edge detection only.
  logic [2:0]  scl_sync_r;
  logic [2:0]  sda_sync_r;
  logic [1:0]  oe_sync_r;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_cond;
  logic        stop_cond;
  logic        sda_s;

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      scl_sync_r <= 3'h7;
      sda_sync_r <= 3'h7;
      oe_sync_r  <= 2'h0;
    end
    else
    begin
      scl_sync_r <= {scl_sync_r[1:0], scl_i};
      sda_sync_r <= {sda_sync_r[1:0], sda_i};
      oe_sync_r  <= {oe_sync_r[0], oe_pin};
    end
  end

  assign sda_s      = sda_sync_r[1];
  assign scl_rise   = scl_sync_r[1] && !scl_sync_r[2];
  assign scl_fall   = !scl_sync_r[1] && scl_sync_r[2];
  assign start_cond = scl_sync_r[1] && scl_sync_r[2] && !sda_s && sda_sync_r[2];
  assign stop_cond  = scl_sync_r[1] && scl_sync_r[2] && sda_s && !sda_sync_r[2];

  // Register state.
  logic [15:0] low_r;
  logic [15:0] low_nxt;
  logic [9:0]  high_r;
  logic [9:0]  high_nxt;
  logic        oe_sw_r;
  logic        oe_sw_nxt;
  logic [3:0]  pr_r;
  logic [3:0]  pr_nxt;
  logic [25:0] word_r;
  logic [25:0] word_nxt;
  logic        commit_r;
  logic        commit_nxt;

  // Protocol state.
  dfcr_state_e state_r;
  dfcr_state_e state_nxt;
  logic [3:0]  cnt_r;
  logic [3:0]  cnt_nxt;
  logic [7:0]  shift_r;
  logic [7:0]  shift_nxt;
  logic [7:0]  tx_r;
  logic [7:0]  tx_nxt;
  logic [7:0]  ptr_r;
  logic [7:0]  ptr_nxt;
  logic        rw_r;
  logic        rw_nxt;
  logic        byte_hi_r;
  logic        byte_hi_nxt;
  logic [7:0]  hold_r;
  logic [7:0]  hold_nxt;
  logic        nack_r;
  logic        nack_nxt;
  logic        wr_fire;
  logic [15:0] wr_data;
  logic        wr_high;
  logic [15:0] rd_cur;
  logic [15:0] rd_inc;

  // Read view of a register; unmapped registers and unused bits return zero.
  function automatic logic [15:0] rd_word(input logic [7:0] p);
    logic [15:0] v;
    v = 16'h0000;
    unique case (p)
      REG_FREQ_LOW:   v = low_r;
      REG_FREQ_HIGH:  v = {5'h00, oe_sw_r, high_r};
      REG_PULL_RANGE: v = {12'h000, pr_r};
      default:        v = 16'h0000;
    endcase
    return v;
  endfunction : rd_word

  assign rd_cur = rd_word(ptr_r);
  assign rd_inc = rd_word(ptr_r + 8'h01);

  always_comb
  begin
    state_nxt   = state_r;
    cnt_nxt     = cnt_r;
    shift_nxt   = shift_r;
    tx_nxt      = tx_r;
    ptr_nxt     = ptr_r;
    rw_nxt      = rw_r;
    byte_hi_nxt = byte_hi_r;
    hold_nxt    = hold_r;
    nack_nxt    = nack_r;
    wr_fire     = 1'b0;
    wr_data     = 16'h0000;
    if (start_cond)
    begin
      state_nxt = ST_ADDR;
      cnt_nxt   = 4'h0;
    end
    else if (stop_cond)
    begin
      state_nxt = ST_IDLE;
    end
    else if (scl_rise)
    begin
      if (state_r == ST_ADDR || state_r == ST_PTR || state_r == ST_WDATA)
      begin
        shift_nxt = {shift_r[6:0], sda_s};
        cnt_nxt   = cnt_r + 4'h1;
      end
      else if (state_r == ST_RDATA)
      begin
        cnt_nxt = cnt_r + 4'h1;
      end
      else if (state_r == ST_RDATA_ACK)
      begin
        nack_nxt = sda_s;
      end
    end
    else if (scl_fall)
    begin
      unique case (state_r)
        ST_IDLE: ;
        ST_ADDR:
          if (cnt_r == BYTE_BITS)
          begin
            state_nxt = (shift_r[7:1] == TARGET_ADDR) ? ST_ADDR_ACK : ST_IDLE;
            rw_nxt    = shift_r[0];
          end
        ST_ADDR_ACK:
        begin
          cnt_nxt = 4'h0;
          if (rw_r)
          begin
            state_nxt   = ST_RDATA;
            byte_hi_nxt = 1'b1;
            tx_nxt      = rd_cur[15:8];
          end
          else
          begin
            state_nxt = ST_PTR;
          end
        end
        ST_PTR:
          if (cnt_r == BYTE_BITS)
          begin
            state_nxt   = ST_PTR_ACK;
            ptr_nxt     = shift_r;
            byte_hi_nxt = 1'b1;
          end
        ST_PTR_ACK, ST_WDATA_ACK:
        begin
          state_nxt = ST_WDATA;
          cnt_nxt   = 4'h0;
        end
        ST_WDATA:
          if (cnt_r == BYTE_BITS)
          begin
            state_nxt = ST_WDATA_ACK;
            if (byte_hi_r)
            begin
              hold_nxt    = shift_r;
              byte_hi_nxt = 1'b0;
            end
            else
            begin
              wr_fire     = 1'b1;
              wr_data     = {hold_r, shift_r};
              ptr_nxt     = ptr_r + 8'h01;
              byte_hi_nxt = 1'b1;
            end
          end
        ST_RDATA:
          if (cnt_r == BYTE_BITS)
            state_nxt = ST_RDATA_ACK;
          else
            tx_nxt = {tx_r[6:0], 1'b0};
        ST_RDATA_ACK:
          if (nack_r)
            state_nxt = ST_IDLE;
          else
          begin
            state_nxt = ST_RDATA;
            cnt_nxt   = 4'h0;
            if (byte_hi_r)
            begin
              byte_hi_nxt = 1'b0;
              tx_nxt      = rd_cur[7:0];
            end
            else
            begin
              byte_hi_nxt = 1'b1;
              ptr_nxt     = ptr_r + 8'h01;
              tx_nxt      = rd_inc[15:8];
            end
          end
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      state_r   <= ST_IDLE;
      cnt_r     <= 4'h0;
      shift_r   <= 8'h00;
      tx_r      <= 8'h00;
      ptr_r     <= 8'h00;
      rw_r      <= 1'b0;
      byte_hi_r <= 1'b1;
      hold_r    <= 8'h00;
      nack_r    <= 1'b0;
    end
    else
    begin
      state_r   <= state_nxt;
      cnt_r     <= cnt_nxt;
      shift_r   <= shift_nxt;
      tx_r      <= tx_nxt;
      ptr_r     <= ptr_nxt;
      rw_r      <= rw_nxt;
      byte_hi_r <= byte_hi_nxt;
      hold_r    <= hold_nxt;
      nack_r    <= nack_nxt;
    end
  end

  assign wr_high = wr_fire && (ptr_r == REG_FREQ_HIGH);

  always_comb
  begin
    low_nxt    = low_r;
    high_nxt   = high_r;
    oe_sw_nxt  = oe_sw_r;
    pr_nxt     = pr_r;
    word_nxt   = word_r;
    commit_nxt = 1'b0;
    if (wr_fire && ptr_r == REG_FREQ_LOW)
      low_nxt = wr_data;
    if (wr_high)
    begin
      high_nxt   = wr_data[HIGH_WORD_W-1:0];
      word_nxt   = {wr_data[HIGH_WORD_W-1:0], low_r};
      commit_nxt = 1'b1;
      if (oe_sw_mode)
        oe_sw_nxt = wr_data[HIGH_OE_BIT];
    end
    if (wr_fire && ptr_r == REG_PULL_RANGE)
      pr_nxt = wr_data[PULL_RANGE_W-1:0];
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      low_r    <= LOW_RESET;
      high_r   <= HIGH_RESET;
      oe_sw_r  <= OE_RESET;
      pr_r     <= PR_RESET;
      word_r   <= FREQ_RESET;
      commit_r <= 1'b0;
    end
    else
    begin
      low_r    <= low_nxt;
      high_r   <= high_nxt;
      oe_sw_r  <= oe_sw_nxt;
      pr_r     <= pr_nxt;
      word_r   <= word_nxt;
      commit_r <= commit_nxt;
    end
  end

  assign sda_o            = 1'b0;
  assign sda_oe           = (state_r == ST_ADDR_ACK) ||
                            (state_r == ST_PTR_ACK) ||
                            (state_r == ST_WDATA_ACK) ||
                            (state_r == ST_RDATA && !tx_r[7]);
  assign out_enable       = oe_sw_mode ? oe_sw_r : oe_sync_r[1];
  assign freq_offset_word = $signed(word_r);
  assign freq_commit      = commit_r;
  assign pull_range_sel   = pr_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_addr_match;
    scl_fall && !start_cond && !stop_cond && state_r == ST_ADDR &&
      cnt_r == BYTE_BITS && shift_r[7:1] == TARGET_ADDR;
  endsequence

  sequence s_high_write;
    wr_high ##1 commit_r;
  endsequence

  chk_low_no_apply: assert property (
    $changed(word_r) |-> $past(wr_high))
    else $error("offset word changed without a high word write");

  chk_commit_atomic: assert property (
    wr_high |=> word_r == {$past(wr_data[9:0]), $past(low_r)})
    else $error("applied word is not staged low with new high");

  chk_commit_pulse: assert property (
    s_high_write |=> !commit_r && word_r[25:16] == high_r)
    else $error("commit pulse or high field wrong");

  chk_reset_zero: assert property (
    disable iff (1'b0) !nrst |=> word_r == FREQ_RESET && !oe_sw_r)
    else $error("offset word or enable not cleared by reset");

  chk_pin_oe_ignored: assert property (
    $changed(oe_sw_r) |-> $past(oe_sw_mode) && $past(wr_high))
    else $error("enable bit changed under pin control");

  chk_oe_disabled: assert property (
    oe_sw_mode && !oe_sw_r |-> !out_enable)
    else $error("output enabled while enable bit is zero");

  chk_sign_value: assert property (
    word_r[25] |-> freq_offset_word < 0)
    else $error("offset word not read as signed");

  chk_hi_unused: assert property (
    $rose(state_r == ST_RDATA) && ptr_r == REG_FREQ_HIGH && byte_hi_r
      |-> tx_r[7:3] == 5'h00)
    else $error("unused high bits read nonzero");

  chk_pr_upper_zero: assert property (
    $rose(state_r == ST_RDATA) && ptr_r == REG_PULL_RANGE
      |-> tx_r[7:4] == 4'h0)
    else $error("range register upper bits read nonzero");

  chk_pr_write: assert property (
    $changed(pr_r) |-> $past(wr_fire) && $past(ptr_r) == REG_PULL_RANGE)
    else $error("range field changed without a write to it");

  chk_addr_ack: assert property (
    s_addr_match |=> sda_oe [*2])
    else $error("address match not acknowledged");

endmodule : dfcr_regs

`default_nettype wire

// File: include/dfcr_pkg.sv
// Constants and types shared by the oscillator control register bank.
package dfcr_pkg;

  localparam logic [7:0]  REG_FREQ_LOW   = 8'h00;
  localparam logic [7:0]  REG_FREQ_HIGH  = 8'h01;
  localparam logic [7:0]  REG_PULL_RANGE = 8'h02;

  localparam int          LOW_WORD_W     = 16;
  localparam int          HIGH_WORD_W    = 10;
  localparam int          FREQ_WORD_W    = 26;
  localparam int          PULL_RANGE_W   = 4;
  localparam int          HIGH_OE_BIT    = 10;

  localparam logic [15:0] LOW_RESET      = 16'h0000;
  localparam logic [9:0]  HIGH_RESET     = 10'h000;
  localparam logic [25:0] FREQ_RESET     = 26'h0000000;
  localparam logic        OE_RESET       = 1'b0;
  localparam logic [3:0]  BYTE_BITS      = 4'h8;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_PTR,
    ST_PTR_ACK,
    ST_WDATA,
    ST_WDATA_ACK,
    ST_RDATA,
    ST_RDATA_ACK
  } dfcr_state_e;

endpackage : dfcr_pkg

// File: tb/dfcr_host.sv
// I2C host model that drives the register bank's serial pins.
`timescale 1ns/1ns
`default_nettype none

module dfcr_host
  import dfcr_pkg::*;
#(
  parameter logic [6:0] ADDR = 7'h2a
)(
  input  wire logic clk,
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_low
);
  initial
  begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end

  task automatic half();
    repeat (8) @(negedge clk);
  endtask : half

  task automatic bit_io(input logic d, output logic q);
    sda_low = ~d;
    half();
    scl = 1'b1;
    half();
    q   = sda_line;
    scl = 1'b0;
    half();
  endtask : bit_io

  task automatic xfer(input logic [7:0] b, input logic nine,
                      output logic [7:0] r, output logic ack);
    logic q;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(b[i], q);
      r[i] = q;
    end
    bit_io(nine, q);
    ack = ~q;
  endtask : xfer

  task automatic start();
    sda_low = 1'b0;
    half();
    scl = 1'b1;
    half();
    sda_low = 1'b1;
    half();
    scl = 1'b0;
    half();
  endtask : start

  task automatic stop();
    sda_low = 1'b1;
    half();
    scl = 1'b1;
    half();
    sda_low = 1'b0;
    half();
  endtask : stop

  task automatic write_word(input logic [6:0] a, input logic [7:0] ptr,
                            input logic [15:0] w, output logic ok);
    logic [7:0] r;
    logic [3:0] k;
    start();
    xfer({a, 1'b0}, 1'b1, r, k[0]);
    xfer(ptr, 1'b1, r, k[1]);
    xfer(w[15:8], 1'b1, r, k[2]);
    xfer(w[7:0], 1'b1, r, k[3]);
    stop();
    ok = &k;
    if (ptr == REG_FREQ_HIGH)
      repeat (6600) @(negedge clk);
  endtask : write_word

  task automatic read_word(input logic [7:0] ptr, output logic [15:0] w);
    logic [7:0] r;
    logic       k;
    start();
    xfer({ADDR, 1'b0}, 1'b1, r, k);
    xfer(ptr, 1'b1, r, k);
    start();
    xfer({ADDR, 1'b1}, 1'b1, r, k);
    xfer(8'hff, 1'b0, w[15:8], k);
    xfer(8'hff, 1'b1, w[7:0], k);
    stop();
  endtask : read_word
endmodule : dfcr_host

`default_nettype wire

// File: tb/tb.sv
// Self-checking bench for the oscillator control register bank.
`timescale 1ns/1ns
`default_nettype none

module tb;
  import dfcr_pkg::*;
  logic               clk, nrst, scl, sda_low, sda_o, sda_oe;
  logic               oe_sw_mode, oe_pin, out_enable, freq_commit, ok;
  logic signed [25:0] freq_offset_word;
  logic [3:0]         pull_range_sel;
  logic [15:0]        rd;
  logic [25:0]        prev = 26'h0000000;
  logic [25:0]        words [2] = '{26'h0666666, 26'h3800000};
  int                 failures = 0;
  int                 n_checks = 0;
  int                 commits = 0;
  wire logic          sda_line = !(sda_low || (sda_oe && !sda_o));

  dfcr_regs u_dut (.clk(clk), .nrst(nrst), .scl_i(scl), .sda_i(sda_line),
    .sda_o(sda_o), .sda_oe(sda_oe), .oe_sw_mode(oe_sw_mode),
    .oe_pin(oe_pin), .out_enable(out_enable),
    .freq_offset_word(freq_offset_word), .freq_commit(freq_commit),
    .pull_range_sel(pull_range_sel));
  dfcr_host u_host (.clk(clk), .sda_line(sda_line), .scl(scl),
    .sda_low(sda_low));

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk)
    if (freq_commit === 1'b1)
      commits <= commits + 1;

  task automatic chk(input logic [25:0] got, input logic [25:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic complete_run();
    $display("checks=%0d mismatches=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : complete_run

  initial
  begin
    #300_000;
    failures++;
    complete_run();
  end

  initial
  begin
    nrst       = 1'b0;
    oe_sw_mode = 1'b1;
    oe_pin     = 1'b0;
    repeat (6) @(negedge clk);
    nrst = 1'b1;
    repeat (4) @(negedge clk);
    chk(freq_offset_word, FREQ_RESET);
    chk(out_enable, OE_RESET);
    chk(pull_range_sel, 4'h0);
    u_host.read_word(REG_FREQ_HIGH, rd);
    chk(rd, 16'h0000);
    $display("test reset done");
    foreach (words[i])
    begin
      u_host.write_word(7'h2a, REG_FREQ_LOW, words[i][15:0], ok);
      chk(freq_offset_word, prev);
      chk(26'(commits), 26'(i));
      u_host.write_word(7'h2a, REG_FREQ_HIGH,
                        {6'h3f, words[i][25:16]}, ok);
      chk(freq_offset_word, words[i]);
      chk(26'(commits), 26'(i + 1));
      chk(freq_offset_word < 0, words[i][25]);
      chk(out_enable, 1'b1);
      u_host.read_word(REG_FREQ_HIGH, rd);
      chk(rd, {6'h01, words[i][25:16]});
      u_host.read_word(REG_FREQ_LOW, rd);
      chk(rd, words[i][15:0]);
      prev = words[i];
    end
    $display("test offset done");
    for (int v = 0; v < 16; v++)
    begin
      u_host.write_word(7'h2a, REG_PULL_RANGE, 16'hfff0 | 16'(v), ok);
      chk(pull_range_sel, v[3:0]);
    end
    u_host.read_word(REG_PULL_RANGE, rd);
    chk(rd, 16'h000f);
    $display("test range done");
    oe_sw_mode = 1'b0;
    repeat (4) @(negedge clk);
    chk(out_enable, 1'b0);
    u_host.write_word(7'h2a, REG_FREQ_HIGH, {6'h00, prev[25:16]}, ok);
    oe_pin = 1'b1;
    repeat (4) @(negedge clk);
    chk(out_enable, 1'b1);
    oe_sw_mode = 1'b1;
    @(negedge clk);
    chk(out_enable, 1'b1);
    $display("test enable done");
    u_host.write_word(7'h2b, REG_FREQ_LOW, 16'h1234, ok);
    chk(ok, 1'b0);
    u_host.read_word(REG_FREQ_LOW, rd);
    chk(rd, prev[15:0]);
    u_host.read_word(8'h03, rd);
    chk(rd, 16'h0000);
    $display("test refusal done");
    complete_run();
  end
endmodule : tb

`default_nettype wire
